/* File: rtl/sgm_timer.sv */
// Signal measure timer: time-of-flight and windowed measure modes with status register
`timescale 1ns/100ps
`default_nettype none

module sgm_timer #(
   parameter int TIMER_W = sgm_pkg::SGM_TIMER_W,
   parameter int DATA_W = sgm_pkg::SGM_DATA_W
) (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_window_input,
   input wire logic i_measured_signal_input,
   input wire logic [3:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_irq
);

   // Rising edge of a synchronous input against its previous sample
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction

   // Register write decode shared by all software-written registers
   function automatic logic wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] target);
      wr_hit = wr & (addr == target);
   endfunction

   // Previous samples for edge detection
   logic window_prev;
   logic signal_prev;
   // Registered window input level gated by enable, shown as the window status
   logic window_level;

   // Control: enable and mode
   logic enable;
   sgm_pkg::sgm_mode_t mode;

   // Sequencer state
   sgm_pkg::sgm_state_t state;
   sgm_pkg::sgm_state_t next_state;

   // Timer and capture registers
   logic [TIMER_W-1:0] measure_timer_reg;
   logic [TIMER_W-1:0] period_capture_reg;
   logic [TIMER_W-1:0] pulse_width_capture_reg;

   // Manual requests, hardware-cleared after one cycle of service
   sgm_pkg::sgm_manual_t manual;

   // Interrupt status and mask
   logic [sgm_pkg::SGM_IRQ_N-1:0] irq_status;
   logic [sgm_pkg::SGM_IRQ_N-1:0] irq_mask;

   // Decoded edges and events of this cycle
   logic win_rise;
   logic sig_rise;
   logic cap_period;
   logic cap_width;
   logic clr_timer;
   logic running;
   sgm_pkg::sgm_event_t event_now;

   // Assembled status register image
   logic [7:0] stat_image;

   assign win_rise = rise(i_window_input, window_prev);
   assign sig_rise = rise(i_measured_signal_input, signal_prev);
   assign running = enable & (state == sgm_pkg::SGM_ST_RUN);

   // Edge-detection history; inputs are already synchronous
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         window_prev <= 1'b0;
         signal_prev <= 1'b0;
         window_level <= 1'b0;
      end else begin
         window_prev <= i_window_input;
         signal_prev <= i_measured_signal_input;
         window_level <= enable & i_window_input;
      end
   end

   // Control register write
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         enable <= sgm_pkg::SGM_CTRL_RESET[sgm_pkg::SGM_CTRL_EN_BIT];
         mode <= sgm_pkg::sgm_mode_t'(sgm_pkg::SGM_CTRL_RESET[sgm_pkg::SGM_CTRL_MODE_BIT]);
      end else if (wr_hit(i_wr, i_addr, sgm_pkg::SGM_ADDR_CTRL)) begin
         enable <= i_wdata[sgm_pkg::SGM_CTRL_EN_BIT];
         mode <= sgm_pkg::sgm_mode_t'(i_wdata[sgm_pkg::SGM_CTRL_MODE_BIT]);
      end
   end

   // Sequencer decode: which capture fires and where the state goes
   always_comb begin
      next_state = state;
      cap_period = 1'b0;
      cap_width = 1'b0;
      clr_timer = 1'b0;
      if (!enable) begin
         // Disabled: park idle so a later enable waits for a fresh window edge
         next_state = sgm_pkg::SGM_ST_IDLE;
      end else begin
         unique case (state)
            sgm_pkg::SGM_ST_IDLE: begin
               if (win_rise) begin
                  next_state = sgm_pkg::SGM_ST_RUN;
                  clr_timer = 1'b1;
               end
            end
            sgm_pkg::SGM_ST_RUN: begin
               if (mode == sgm_pkg::SGM_MODE_TOF) begin
                  if (sig_rise) begin
                     cap_period = 1'b1;
                     clr_timer = 1'b1;
                     next_state = sgm_pkg::SGM_ST_IDLE;
                  end else if (win_rise) begin
                     cap_width = 1'b1;
                     clr_timer = 1'b1;
                  end
               end else begin
                  if (win_rise) begin
                     cap_period = 1'b1;
                     clr_timer = 1'b1;
                  end
               end
            end
            default: begin
               next_state = sgm_pkg::SGM_ST_IDLE;
            end
         endcase
      end
   end

   // Sequencer state register
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state <= sgm_pkg::SGM_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Measurement timer: manual reset, the run start and edge captures clear it, running increments it
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         measure_timer_reg <= '0;
      end else if (manual.tmr_rst) begin
         measure_timer_reg <= '0;
      end else if (clr_timer) begin
         measure_timer_reg <= '0;
      end else if (running) begin
         measure_timer_reg <= measure_timer_reg + TIMER_W'(1);
      end
   end

   // Period capture register
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         period_capture_reg <= '0;
      end else if (cap_period) begin
         period_capture_reg <= measure_timer_reg;
      end else if (manual.period_upd) begin
         period_capture_reg <= measure_timer_reg;
      end
   end

   // Pulse-width capture register
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         pulse_width_capture_reg <= '0;
      end else if (cap_width) begin
         pulse_width_capture_reg <= measure_timer_reg;
      end else if (manual.width_upd) begin
         pulse_width_capture_reg <= measure_timer_reg;
      end
   end

   // Manual request bits: set by a software one, cleared once serviced.
   // Service takes the cycle after the set; a new one written in that
   // same cycle wins, so a back-to-back request is never lost.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         manual <= '0;
      end else begin
         manual.period_upd <= wr_hit(i_wr, i_addr, sgm_pkg::SGM_ADDR_STAT)
                              & i_wdata[sgm_pkg::SGM_STAT_PERIOD_UPD_BIT];
         manual.width_upd <= wr_hit(i_wr, i_addr, sgm_pkg::SGM_ADDR_STAT)
                             & i_wdata[sgm_pkg::SGM_STAT_WIDTH_UPD_BIT];
         manual.tmr_rst <= wr_hit(i_wr, i_addr, sgm_pkg::SGM_ADDR_STAT)
                           & i_wdata[sgm_pkg::SGM_STAT_TMR_RST_BIT];
      end
   end

   // Status register image
   always_comb begin
      stat_image = sgm_pkg::SGM_STAT_RESET;
      stat_image[sgm_pkg::SGM_STAT_PERIOD_UPD_BIT] = manual.period_upd;
      stat_image[sgm_pkg::SGM_STAT_WIDTH_UPD_BIT] = manual.width_upd;
      stat_image[sgm_pkg::SGM_STAT_TMR_RST_BIT] = manual.tmr_rst;
      stat_image[sgm_pkg::SGM_STAT_RUNNING_BIT] = running;
      stat_image[sgm_pkg::SGM_STAT_WINDOW_BIT] = window_level;
      stat_image[sgm_pkg::SGM_STAT_ACQ_BIT] = enable & (state != sgm_pkg::SGM_ST_IDLE);
   end

   // Interrupt events of this cycle; wrap flags a timer rolling over
   always_comb begin
      event_now.period = cap_period;
      event_now.width = cap_width;
      event_now.wrap = running & ~clr_timer & ~manual.tmr_rst & (&measure_timer_reg);
   end

   // Sticky interrupt status: write one clears, a same-cycle event wins
   genvar g;
   generate
      for (g = 0; g < sgm_pkg::SGM_IRQ_N; g++) begin : g_irq
         always_ff @(posedge i_clock) begin
            if (i_srst) begin
               irq_status[g] <= sgm_pkg::SGM_IRQ_RESET[g];
            end else if (event_now[g]) begin
               irq_status[g] <= 1'b1;
            end else if (wr_hit(i_wr, i_addr, sgm_pkg::SGM_ADDR_IRQ_STAT) && i_wdata[g]) begin
               irq_status[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // Interrupt mask register
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         irq_mask <= sgm_pkg::SGM_IRQ_RESET;
      end else if (wr_hit(i_wr, i_addr, sgm_pkg::SGM_ADDR_IRQ_MASK)) begin
         irq_mask <= i_wdata[sgm_pkg::SGM_IRQ_N-1:0];
      end
   end

   // Interrupt line, registered; one cycle behind the status bits
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status & irq_mask);
      end
   end

   // Read data: valid only the cycle after the read strobe, zero otherwise.
   // Unmapped offsets read zero so software probing never sees stale data.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_rdata <= '0;
      end else if (i_rd) begin
         unique case (i_addr)
            sgm_pkg::SGM_ADDR_CTRL: begin
               o_rdata <= DATA_W'({mode, enable});
            end
            sgm_pkg::SGM_ADDR_STAT: begin
               o_rdata <= DATA_W'(stat_image);
            end
            sgm_pkg::SGM_ADDR_TIMER: begin
               o_rdata <= DATA_W'(measure_timer_reg);
            end
            sgm_pkg::SGM_ADDR_PERIOD: begin
               o_rdata <= DATA_W'(period_capture_reg);
            end
            sgm_pkg::SGM_ADDR_WIDTH: begin
               o_rdata <= DATA_W'(pulse_width_capture_reg);
            end
            sgm_pkg::SGM_ADDR_IRQ_STAT: begin
               o_rdata <= DATA_W'(irq_status);
            end
            sgm_pkg::SGM_ADDR_IRQ_MASK: begin
               o_rdata <= DATA_W'(irq_mask);
            end
            default: begin
               o_rdata <= '0;
            end
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

endmodule // sgm_timer

`default_nettype wire

/* File: rtl/sgm_pkg.sv */
// Package for the signal measure timer: register map, field layout, reset values and types
package sgm_pkg;

   // Register offsets on the plain register port
   localparam logic [3:0] SGM_ADDR_CTRL = 4'h0;
   localparam logic [3:0] SGM_ADDR_STAT = 4'h1;
   localparam logic [3:0] SGM_ADDR_TIMER = 4'h2;
   localparam logic [3:0] SGM_ADDR_PERIOD = 4'h3;
   localparam logic [3:0] SGM_ADDR_WIDTH = 4'h4;
   localparam logic [3:0] SGM_ADDR_IRQ_STAT = 4'h5;
   localparam logic [3:0] SGM_ADDR_IRQ_MASK = 4'h6;

   // Control register fields
   localparam int SGM_CTRL_EN_BIT = 0;
   localparam int SGM_CTRL_MODE_BIT = 1;
   localparam logic [1:0] SGM_CTRL_RESET = 2'h0;

   // Status and manual-control register fields
   localparam int SGM_STAT_PERIOD_UPD_BIT = 7;
   localparam int SGM_STAT_WIDTH_UPD_BIT = 6;
   localparam int SGM_STAT_TMR_RST_BIT = 5;
   localparam int SGM_STAT_RUNNING_BIT = 2;
   localparam int SGM_STAT_WINDOW_BIT = 1;
   localparam int SGM_STAT_ACQ_BIT = 0;
   localparam logic [7:0] SGM_STAT_RESET = 8'h00;

   // Interrupt event bits
   localparam int SGM_IRQ_PERIOD_BIT = 0;
   localparam int SGM_IRQ_WIDTH_BIT = 1;
   localparam int SGM_IRQ_WRAP_BIT = 2;
   localparam int SGM_IRQ_N = 3;
   localparam logic [2:0] SGM_IRQ_RESET = 3'h0;

   // Default widths
   localparam int SGM_TIMER_W = 24;
   localparam int SGM_DATA_W = 32;

   // Measurement modes
   typedef enum logic {
      SGM_MODE_TOF = 1'b0,
      SGM_MODE_WINDOWED = 1'b1
   } sgm_mode_t;

   // Measurement sequencer states, Gray along idle to run
   typedef enum logic [1:0] {
      SGM_ST_IDLE = 2'b00,
      SGM_ST_RUN = 2'b01
   } sgm_state_t;

   // Manual requests held in the status register
   typedef struct packed {
      logic period_upd;
      logic width_upd;
      logic tmr_rst;
   } sgm_manual_t;

   // Interrupt events raised in one cycle: the two captures and the timer wrap
   typedef struct packed {
      logic wrap;
      logic width;
      logic period;
   } sgm_event_t;

endpackage : sgm_pkg

/* File: tb/sgm_timer_sva.sv */
// Port checker for the signal measure timer
`timescale 1ns/100ps
`default_nettype none
module sgm_timer_chk #(
   parameter int DATA_W = 32
) (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_window_input,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [3:0] i_addr,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);
   // Read data stands only after a read
   property p_rd_idle; !$past(i_rd) |-> o_rdata == '0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   // Reset must clear read data, so this one ignores the default disable
   property p_rst_rdata; disable iff (1'b0) i_srst |=> o_rdata == '0; endproperty
   a_rst_rdata: assert property (p_rst_rdata) else $error("read data after reset");
   property p_irq_rst; $fell(i_srst) |-> !o_irq; endproperty
   a_irq_rst: assert property (p_irq_rst) else $error("irq high after reset");
   property p_stat_zero;
      $past(i_rd) && $past(i_addr) == sgm_pkg::SGM_ADDR_STAT |-> o_rdata[4:3] == 2'h0 && o_rdata[DATA_W-1:8] == '0;
   endproperty
   a_stat_zero: assert property (p_stat_zero) else $error("unused status bits set");
   property p_unmapped; $past(i_rd) && $past(i_addr) > 4'h6 |-> o_rdata == '0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   // Running and acquisition both follow the run state
   property p_run_acq;
      $past(i_rd) && $past(i_addr) == sgm_pkg::SGM_ADDR_STAT |-> o_rdata[2] == o_rdata[0];
   endproperty
   a_run_acq: assert property (p_run_acq) else $error("running and acquisition differ");
   // Requests live one cycle, so a read not right after a write sees them cleared
   property p_manual_clear;
      $past(i_rd) && $past(i_addr) == sgm_pkg::SGM_ADDR_STAT && !$past(i_wr, 2) |-> o_rdata[7:5] == 3'h0;
   endproperty
   a_manual_clear: assert property (p_manual_clear) else $error("request bit not cleared");
   property p_win_flag;
      $past(i_rd) && $past(i_addr) == sgm_pkg::SGM_ADDR_STAT && o_rdata[1] |-> $past(i_window_input, 2);
   endproperty
   a_win_flag: assert property (p_win_flag) else $error("window flag without window");
endmodule // sgm_timer_chk
bind sgm_timer sgm_timer_chk #(.DATA_W(DATA_W)) chk_i (.i_clock(i_clock), .i_srst(i_srst),
   .i_window_input(i_window_input), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .o_rdata(o_rdata), .o_irq(o_irq));
`default_nettype wire

/* File: tb/sgm_src.sv */
// Source model for the window and measured signal inputs
`timescale 1ns/100ps
`default_nettype none
module sgm_src (
   input wire logic i_clock,
   output var logic o_window,
   output var logic o_signal
);
   // Both lines idle low
   initial begin
      o_window = 1'b0;
      o_signal = 1'b0;
   end
   // Levels change just after an edge so the design sees them cleanly
   task automatic set_win(input logic v);
      @(posedge i_clock);
      o_window <= v;
   endtask
   task automatic set_sig(input logic v);
      @(posedge i_clock);
      o_signal <= v;
   endtask
endmodule // sgm_src
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the signal measure timer
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic i_clock = 1'b0; // 10 MHz clock
   logic i_srst = 1'b1; // Held for 20 cycles
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic o_irq;
   logic win; // Window line from the source model
   logic sig; // Measured line from the source model
   int miscompares = 0;
   int n_checks = 0;
   integer seed = 32'hb2de;
   int m_period = 0; // Model captures
   int m_width = 0;
   bit m_run = 1'b0; // Model run state
   bit m_wnd = 1'b0; // Model windowed mode
   time t0 = 0; // Edge time of the last timer clear
   always #50 i_clock = ~i_clock;
   sgm_timer sgm_timer_i (.i_clock(i_clock), .i_srst(i_srst), .i_window_input(win), .i_measured_signal_input(sig),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq));
   sgm_src sgm_src_i (.i_clock(i_clock), .o_window(win), .o_signal(sig));
   task automatic tally_and_finish();
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // Random spacing, so the source answers both promptly and slowly
   function automatic int gap();
      return 2 + ($random(seed) & 7);
   endfunction
   // Count a capture loads: the timer clears on the starting edge and only counts from the next one
   function automatic int elapsed();
      return int'(($time - t0) / 100) - 1;
   endfunction
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
      // Junk on the idle bus must not reach any register
      i_addr <= 4'($random(seed));
      i_wdata <= 32'($random(seed));
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rc(input logic [3:0] a, input logic [31:0] exp);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      i_addr <= 4'($random(seed));
      #1 chk(o_rdata, exp);
   endtask
   // Window rise: starts the run, or captures a count from the last clear
   task automatic win_rise();
      sgm_src_i.set_win(1'b1);
      if (m_run && !m_wnd) m_width = elapsed();
      if (m_run && m_wnd) m_period = elapsed();
      m_run = 1'b1;
      t0 = $time;
   endtask
   task automatic sig_rise();
      sgm_src_i.set_sig(1'b1);
      if (m_run && !m_wnd) begin
         m_period = elapsed();
         m_run = 1'b0;
      end
      sgm_src_i.set_sig(1'b0);
   endtask
   initial begin
      tick(20);
      i_srst <= 1'b0;
      for (int a = 0; a < 16; a++) rc(a[3:0], 32'h0);
      for (int r = 0; r < 3; r++) begin
         m_wnd = 1'b0;
         // Upper data bits are random and must be ignored
         wr(sgm_pkg::SGM_ADDR_CTRL, 32'h1 | (32'($random(seed)) & 32'hffff_fffc));
         wr(sgm_pkg::SGM_ADDR_IRQ_MASK, 32'h1 | (32'($random(seed)) & 32'hffff_fff8));
         rc(sgm_pkg::SGM_ADDR_CTRL, 32'h1);
         rc(sgm_pkg::SGM_ADDR_IRQ_MASK, 32'h1);
         win_rise();
         tick(gap());
         rc(sgm_pkg::SGM_ADDR_STAT, 32'h7);
         sig_rise();
         rc(sgm_pkg::SGM_ADDR_STAT, 32'h2);
         sgm_src_i.set_win(1'b0);
         rc(sgm_pkg::SGM_ADDR_PERIOD, 32'(m_period));
         chk({31'h0, o_irq}, 32'h1);
         // two window edges, then a signal edge
         win_rise();
         tick(gap());
         sgm_src_i.set_win(1'b0);
         win_rise();
         sgm_src_i.set_win(1'b0);
         tick(gap());
         sig_rise();
         rc(sgm_pkg::SGM_ADDR_WIDTH, 32'(m_width));
         rc(sgm_pkg::SGM_ADDR_PERIOD, 32'(m_period));
         rc(sgm_pkg::SGM_ADDR_IRQ_STAT, 32'h3);
         wr(sgm_pkg::SGM_ADDR_IRQ_STAT, 32'h7);
         tick(2);
         #1 chk({31'h0, o_irq}, 32'h0);
         // all requests at once while idle, timer is zero
         wr(sgm_pkg::SGM_ADDR_STAT, 32'hf8);
         m_period = 0;
         m_width = 0;
         rc(sgm_pkg::SGM_ADDR_STAT, 32'h0);
         rc(sgm_pkg::SGM_ADDR_PERIOD, 32'(m_period));
         rc(sgm_pkg::SGM_ADDR_WIDTH, 32'(m_width));
         rc(sgm_pkg::SGM_ADDR_TIMER, 32'h0);
         m_wnd = 1'b1;
         wr(sgm_pkg::SGM_ADDR_CTRL, 32'h3);
         win_rise();
         sgm_src_i.set_win(1'b0);
         tick(gap());
         win_rise();
         sgm_src_i.set_win(1'b0);
         rc(sgm_pkg::SGM_ADDR_PERIOD, 32'(m_period));
         tick(gap());
         rc(sgm_pkg::SGM_ADDR_PERIOD, 32'(m_period));
         // timer reset while running, then load the restarted count
         wr(sgm_pkg::SGM_ADDR_STAT, 32'h20);
         t0 = $time;
         rc(sgm_pkg::SGM_ADDR_TIMER, 32'h0);
         wr(sgm_pkg::SGM_ADDR_STAT, 32'hc0);
         m_period = elapsed();
         m_width = m_period;
         rc(sgm_pkg::SGM_ADDR_PERIOD, 32'(m_period));
         rc(sgm_pkg::SGM_ADDR_WIDTH, 32'(m_width));
         wr(sgm_pkg::SGM_ADDR_CTRL, 32'h0);
         m_run = 1'b0;
         wr(sgm_pkg::SGM_ADDR_IRQ_STAT, 32'h7);
      end
      // a reset after the run is disabled clears the held timer, period capture and mask
      tick(1);
      i_srst <= 1'b1;
      tick(2);
      i_srst <= 1'b0;
      rc(sgm_pkg::SGM_ADDR_TIMER, 32'h0);
      rc(sgm_pkg::SGM_ADDR_PERIOD, 32'h0);
      rc(sgm_pkg::SGM_ADDR_IRQ_MASK, 32'h0);
      tally_and_finish();
   end
   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      #5000000;
      miscompares++;
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
